// ===== verilog/bridge_window_pkg.sv
// Constants, field layout and reset values of the bridge window register bank
// ****************************************************************************
// Operation
// - Limit low bit 0 mirrors 64-bit prefetch flag
// - Limit low bits 15:4 hold A31:20, low F_FFFF
// - Base high register gives base A63:32
// - Limit high register gives limit A63:32
// - Prefetch flag clear: high registers zero, read-only
// - I/O base high gives I/O base A31:16
// - I/O limit high gives I/O limit A31:16
// - I/O 32-bit flag clear: I/O highs zero
// - Capability list head readable, lockable, not free
// - Option ROM base always zero, writes ignored
// - IRQ scratch stores written low byte, resets zero
// - Prefetch flag selects 64-bit, resets one, lockable
// - Base low bits 15:4 hold A31:20, 1MB aligned
// ****************************************************************************
package bridge_window_pkg;
   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_IO_LOW = 10'h01C;
   localparam logic [9:0] IDX_PF_BASE_LO = 10'h024;
   localparam logic [9:0] IDX_PF_LIMIT_LO = 10'h026;
   localparam logic [9:0] IDX_PF_BASE_HI = 10'h028;
   localparam logic [9:0] IDX_PF_LIMIT_HI = 10'h02C;
   localparam logic [9:0] IDX_IO_BASE_HI = 10'h030;
   localparam logic [9:0] IDX_IO_LIMIT_HI = 10'h032;
   localparam logic [9:0] IDX_CAP_HEAD = 10'h034;
   localparam logic [9:0] IDX_ROM_BASE = 10'h038;
   localparam logic [9:0] IDX_IRQ_SCRATCH = 10'h03C;
   localparam logic [9:0] IDX_LOCK = 10'h0F0;
   // Field positions
   localparam int unsigned PF_CAP_BIT = 0;
   localparam int unsigned PF_ADDR_LSB = 4;
   localparam int unsigned PF_ADDR_MSB = 15;
   localparam int unsigned IO_CAP_BIT = 0;
   localparam int unsigned IO_BASE_LSB = 4;
   localparam int unsigned IO_LIMIT_LSB = 12;
   localparam int unsigned LOCK_BIT = 0;
   // Reset values
   localparam logic RST_PF_CAP = 1'b1;
   localparam logic [11:0] RST_PF_BASE_LO = 12'hFFF;
   localparam logic [11:0] RST_PF_LIMIT_LO = 12'h000;
   localparam logic [31:0] RST_PF_BASE_HI = 32'hFFFF_FFFF;
   localparam logic [31:0] RST_PF_LIMIT_HI = 32'h0000_0000;
   localparam logic [15:0] RST_IO_BASE_HI = 16'hFFFF;
   localparam logic [15:0] RST_IO_LIMIT_HI = 16'h0000;
   localparam logic RST_IO_CAP = 1'b1;
   localparam logic [3:0] RST_IO_BASE_LO = 4'hF;
   localparam logic [3:0] RST_IO_LIMIT_LO = 4'h0;
   localparam logic [7:0] RST_CAP_HEAD = 8'h40;
   localparam logic [7:0] RST_IRQ_SCRATCH = 8'h00;
   localparam logic [31:0] ROM_BASE_VALUE = 32'h0000_0000;
   localparam logic RST_LOCK = 1'b0;
   // Implied low address bits of a window top
   localparam logic [19:0] PF_LOW_FILL = 20'hF_FFFF;
   localparam logic [11:0] IO_LOW_FILL = 12'hFFF;
   // Bus answer states
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_state_t;
endpackage : bridge_window_pkg

// ===== verilog/window_range_check.sv
// Inclusive address window comparator
`timescale 1ns/1ps
module window_range_check
   import bridge_window_pkg::*;
#(
   parameter int unsigned AW = 64
)
(
   // Probe and window bounds
   input wire logic [AW-1:0] addr_i,
   input wire logic [AW-1:0] base_i,
   input wire logic [AW-1:0] limit_i,
   // Result
   output logic hit_o
);
   // Inside when base <= addr <= limit
   assign hit_o = (addr_i >= base_i) && (addr_i <= limit_i);
endmodule : window_range_check

// ===== verilog/bridge_window_upper_config_regs.sv
// Bridge window upper configuration registers with Wishbone slave and window decode
`timescale 1ns/1ps
module bridge_window_upper_config_regs
   import bridge_window_pkg::*;
#(
   parameter logic [7:0] CAP_HEAD_RESET = RST_CAP_HEAD
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DATA_W-1:0] wb_dat_i,
   output logic [DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Window probes
   input wire logic [63:0] pf_probe_addr_i,
   input wire logic [31:0] io_probe_addr_i,
   output logic pf_hit_o,
   output logic io_hit_o
);

   // ************************************************************************
   // Helpers
   // ************************************************************************

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // Index match
   function automatic logic addr_is(input logic [9:0] idx, input logic [9:0] target);
      return idx == target;
   endfunction : addr_is

   // ************************************************************************
   // State
   // ************************************************************************

   bus_state_t bus_state_q, bus_state_d;
   logic [31:0] dat_q, dat_d;
   logic pf_cap_q, pf_cap_d;
   logic [11:0] pf_base_lo_q, pf_base_lo_d;
   logic [11:0] pf_limit_lo_q, pf_limit_lo_d;
   logic [31:0] pf_base_hi_q, pf_base_hi_d;
   logic [31:0] pf_limit_hi_q, pf_limit_hi_d;
   logic io_cap_q, io_cap_d;
   logic [3:0] io_base_lo_q, io_base_lo_d;
   logic [3:0] io_limit_lo_q, io_limit_lo_d;
   logic [15:0] io_base_hi_q, io_base_hi_d;
   logic [15:0] io_limit_hi_q, io_limit_hi_d;
   logic [7:0] cap_head_q, cap_head_d;
   logic [7:0] irq_q, irq_d;
   logic lock_q, lock_d;
   logic pf_hit_q, io_hit_q;
   logic [9:0] idx;
   logic req;
   logic wr_fire;
   logic [31:0] rd_word;
   logic [31:0] wr_word;
   logic [63:0] pf_base_full, pf_limit_full;
   logic [31:0] io_base_full, io_limit_full;
   logic pf_hit_c, io_hit_c;

   assign idx = wb_adr_i[ADDR_W-1:2];
   assign req = wb_cyc_i && wb_stb_i;
   // Write lands on the edge where ack is seen high
   assign wr_fire = req && wb_we_i && (bus_state_q == BUS_ACK);

   // ************************************************************************
   // Read mux
   // ************************************************************************

   // Current value of the addressed register, unmapped reads zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (addr_is(idx, IDX_PF_BASE_LO))
      begin
         rd_word = {16'h0000, pf_base_lo_q, 3'h0, pf_cap_q};
      end
      else if (addr_is(idx, IDX_PF_LIMIT_LO))
      begin
         rd_word = {16'h0000, pf_limit_lo_q, 3'h0, pf_cap_q};
      end
      else if (addr_is(idx, IDX_PF_BASE_HI))
      begin
         rd_word = pf_base_hi_q;
      end
      else if (addr_is(idx, IDX_PF_LIMIT_HI))
      begin
         rd_word = pf_limit_hi_q;
      end
      else if (addr_is(idx, IDX_IO_BASE_HI))
      begin
         rd_word = {16'h0000, io_base_hi_q};
      end
      else if (addr_is(idx, IDX_IO_LIMIT_HI))
      begin
         rd_word = {16'h0000, io_limit_hi_q};
      end
      else if (addr_is(idx, IDX_CAP_HEAD))
      begin
         rd_word = {24'h00_0000, cap_head_q};
      end
      else if (addr_is(idx, IDX_ROM_BASE))
      begin
         rd_word = ROM_BASE_VALUE;
      end
      else if (addr_is(idx, IDX_IRQ_SCRATCH))
      begin
         rd_word = {24'h00_0000, irq_q};
      end
      else if (addr_is(idx, IDX_IO_LOW))
      begin
         rd_word = {16'h0000, io_limit_lo_q, 4'h0, io_base_lo_q, 3'h0, io_cap_q};
      end
      else if (addr_is(idx, IDX_LOCK))
      begin
         rd_word = {31'h0000_0000, lock_q};
      end
   end

   assign wr_word = merge_bytes(rd_word, wb_dat_i, wb_sel_i);

   // ************************************************************************
   // Bus answer and register update
   // ************************************************************************

   // Next values of bus state and all registers except the hit flags
   always_comb
   begin
      bus_state_d = bus_state_q;
      dat_d = dat_q;
      pf_cap_d = pf_cap_q;
      pf_base_lo_d = pf_base_lo_q;
      pf_limit_lo_d = pf_limit_lo_q;
      pf_base_hi_d = pf_base_hi_q;
      pf_limit_hi_d = pf_limit_hi_q;
      io_cap_d = io_cap_q;
      io_base_lo_d = io_base_lo_q;
      io_limit_lo_d = io_limit_lo_q;
      io_base_hi_d = io_base_hi_q;
      io_limit_hi_d = io_limit_hi_q;
      cap_head_d = cap_head_q;
      irq_d = irq_q;
      lock_d = lock_q;
      case (bus_state_q)
         BUS_IDLE:
         begin
            if (req)
            begin
               bus_state_d = BUS_ACK;
               dat_d = rd_word;
            end
         end
         BUS_ACK:
         begin
            bus_state_d = BUS_IDLE;
         end
         default:
         begin
            bus_state_d = BUS_IDLE;
         end
      endcase
      if (wr_fire)
      begin
         if (addr_is(idx, IDX_PF_BASE_LO))
         begin
            pf_base_lo_d = wr_word[PF_ADDR_MSB:PF_ADDR_LSB];
            if (!lock_q)
            begin
               pf_cap_d = wr_word[PF_CAP_BIT];
            end
         end
         else if (addr_is(idx, IDX_PF_LIMIT_LO))
         begin
            pf_limit_lo_d = wr_word[PF_ADDR_MSB:PF_ADDR_LSB];
         end
         else if (addr_is(idx, IDX_PF_BASE_HI))
         begin
            pf_base_hi_d = wr_word;
         end
         else if (addr_is(idx, IDX_PF_LIMIT_HI))
         begin
            pf_limit_hi_d = wr_word;
         end
         else if (addr_is(idx, IDX_IO_BASE_HI))
         begin
            io_base_hi_d = wr_word[15:0];
         end
         else if (addr_is(idx, IDX_IO_LIMIT_HI))
         begin
            io_limit_hi_d = wr_word[15:0];
         end
         else if (addr_is(idx, IDX_CAP_HEAD))
         begin
            if (!lock_q)
            begin
               cap_head_d = wr_word[7:0];
            end
         end
         else if (addr_is(idx, IDX_IRQ_SCRATCH))
         begin
            irq_d = wr_word[7:0];
         end
         else if (addr_is(idx, IDX_IO_LOW))
         begin
            io_cap_d = wr_word[IO_CAP_BIT];
            io_base_lo_d = wr_word[IO_BASE_LSB +: 4];
            io_limit_lo_d = wr_word[IO_LIMIT_LSB +: 4];
         end
         else if (addr_is(idx, IDX_LOCK))
         begin
            lock_d = lock_q | wr_word[LOCK_BIT];
         end
      end
      // Upper halves held at zero while their capability is off
      if (!pf_cap_d)
      begin
         pf_base_hi_d = 32'h0000_0000;
         pf_limit_hi_d = 32'h0000_0000;
      end
      if (!io_cap_d)
      begin
         io_base_hi_d = 16'h0000;
         io_limit_hi_d = 16'h0000;
      end
   end

   // Register all state except the hit flags
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bus_state_q <= BUS_IDLE;
         dat_q <= 32'h0000_0000;
         pf_cap_q <= RST_PF_CAP;
         pf_base_lo_q <= RST_PF_BASE_LO;
         pf_limit_lo_q <= RST_PF_LIMIT_LO;
         pf_base_hi_q <= RST_PF_BASE_HI;
         pf_limit_hi_q <= RST_PF_LIMIT_HI;
         io_cap_q <= RST_IO_CAP;
         io_base_lo_q <= RST_IO_BASE_LO;
         io_limit_lo_q <= RST_IO_LIMIT_LO;
         io_base_hi_q <= RST_IO_BASE_HI;
         io_limit_hi_q <= RST_IO_LIMIT_HI;
         cap_head_q <= CAP_HEAD_RESET;
         irq_q <= RST_IRQ_SCRATCH;
         lock_q <= RST_LOCK;
      end
      else
      begin
         bus_state_q <= bus_state_d;
         dat_q <= dat_d;
         pf_cap_q <= pf_cap_d;
         pf_base_lo_q <= pf_base_lo_d;
         pf_limit_lo_q <= pf_limit_lo_d;
         pf_base_hi_q <= pf_base_hi_d;
         pf_limit_hi_q <= pf_limit_hi_d;
         io_cap_q <= io_cap_d;
         io_base_lo_q <= io_base_lo_d;
         io_limit_lo_q <= io_limit_lo_d;
         io_base_hi_q <= io_base_hi_d;
         io_limit_hi_q <= io_limit_hi_d;
         cap_head_q <= cap_head_d;
         irq_q <= irq_d;
         lock_q <= lock_d;
      end
   end

   // ************************************************************************
   // Window decode
   // ************************************************************************

   // Full bounds: high half joined above low half
   assign pf_base_full = {pf_base_hi_q, pf_base_lo_q, 20'h0_0000};
   assign pf_limit_full = {pf_limit_hi_q, pf_limit_lo_q, PF_LOW_FILL};
   assign io_base_full = {io_base_hi_q, io_base_lo_q, 12'h000};
   assign io_limit_full = {io_limit_hi_q, io_limit_lo_q, IO_LOW_FILL};

   window_range_check #(.AW(64)) u_pf_check (
      .addr_i(pf_probe_addr_i),
      .base_i(pf_base_full),
      .limit_i(pf_limit_full),
      .hit_o(pf_hit_c)
   );

   window_range_check #(.AW(32)) u_io_check (
      .addr_i(io_probe_addr_i),
      .base_i(io_base_full),
      .limit_i(io_limit_full),
      .hit_o(io_hit_c)
   );

   // Registered hit flags
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pf_hit_q <= 1'b0;
         io_hit_q <= 1'b0;
      end
      else
      begin
         pf_hit_q <= pf_hit_c;
         io_hit_q <= io_hit_c;
      end
   end

   assign wb_ack_o = (bus_state_q == BUS_ACK);
   assign wb_dat_o = dat_q;
   assign pf_hit_o = pf_hit_q;
   assign io_hit_o = io_hit_q;

   // ************************************************************************
   // Checks
   // ************************************************************************

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_read_at(logic [9:0] t);
      req && !wb_we_i && !wb_ack_o && idx == t;
   endsequence

   sequence s_write_at(logic [9:0] t);
      wr_fire && idx == t && wb_sel_i == 4'hF;
   endsequence

   a_limit_cap_mirror: assert property (s_read_at(IDX_PF_LIMIT_LO) |=>
      wb_ack_o && wb_dat_o[0] == $past(pf_cap_q))
      else $error("limit low bit 0 differs from prefetch flag");

   a_limit_low_write: assert property (s_write_at(IDX_PF_LIMIT_LO) |=>
      pf_limit_lo_q == $past(wb_dat_i[15:4]))
      else $error("limit low field not written");

   a_base_high_write: assert property (s_write_at(IDX_PF_BASE_HI) && pf_cap_q |=>
      pf_base_hi_q == $past(wb_dat_i))
      else $error("base high not written");

   a_limit_high_join: assert property (s_write_at(IDX_PF_LIMIT_HI) && pf_cap_q |=>
      pf_limit_full[63:32] == $past(wb_dat_i) && pf_limit_full[19:0] == 20'hF_FFFF)
      else $error("limit high not joined");

   a_pf_upper_zero: assert property (!pf_cap_q |->
      pf_base_hi_q == 32'h0000_0000 && pf_limit_hi_q == 32'h0000_0000)
      else $error("prefetch upper nonzero while flag clear");

   a_io_upper_zero: assert property (!io_cap_q |->
      io_base_hi_q == 16'h0000 && io_limit_hi_q == 16'h0000)
      else $error("I/O upper nonzero while flag clear");

   a_io_base_write: assert property (s_write_at(IDX_IO_BASE_HI) && io_cap_q |=>
      io_base_full[31:16] == $past(wb_dat_i[15:0]))
      else $error("I/O base high not written");

   a_io_limit_write: assert property (s_write_at(IDX_IO_LIMIT_HI) && io_cap_q |=>
      io_limit_full[31:16] == $past(wb_dat_i[15:0]))
      else $error("I/O limit high not written");

   a_lock_holds: assert property (lock_q |=> $stable(cap_head_q) && $stable(pf_cap_q))
      else $error("locked field changed");

   a_rom_zero: assert property (s_read_at(IDX_ROM_BASE) |=> wb_dat_o == 32'h0000_0000)
      else $error("option ROM base not zero");

   a_scratch_back: assert property (s_write_at(IDX_IRQ_SCRATCH) ##2
      s_read_at(IDX_IRQ_SCRATCH) |=> wb_dat_o[7:0] == $past(wb_dat_i[7:0], 3))
      else $error("scratch readback wrong");

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   a_ack_latency: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");

   a_base_align: assert property (s_write_at(IDX_PF_BASE_LO) |=>
      pf_base_full[31:0] == {$past(wb_dat_i[15:4]), 20'h0_0000})
      else $error("prefetch base not 1MB aligned");

   a_hit_follow: assert property (1'b1 |=> pf_hit_o == $past(pf_hit_c))
      else $error("prefetch hit not registered");

endmodule : bridge_window_upper_config_regs

// ===== bench/tb.sv
// Self-checking testbench of the bridge window upper configuration registers
`timescale 1ns/1ps
module tb
   import bridge_window_pkg::*;
;
   // ****************************************************************
   // Compare macro, signals and table of ordinary cases
   // ****************************************************************
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("ERROR %0t: got %h expected %h", $time, got, exp); \
      end \
   end

   typedef struct packed {
      logic we;
      logic [9:0] idx;
      logic [31:0] dat;
      logic [3:0] sel;
      logic [31:0] exp;
   } row_t;

   localparam int NROWS = 19;
   localparam row_t ROWS [0:NROWS-1] = '{
      '{1'b0, IDX_PF_BASE_LO, 32'h0, 4'hF, 32'h0000_FFF1},
      '{1'b0, IDX_PF_LIMIT_LO, 32'h0, 4'hF, 32'h0000_0001},
      '{1'b0, IDX_PF_BASE_HI, 32'h0, 4'hF, 32'hFFFF_FFFF},
      '{1'b0, IDX_PF_LIMIT_HI, 32'h0, 4'hF, 32'h0000_0000},
      '{1'b0, IDX_IO_BASE_HI, 32'h0, 4'hF, 32'h0000_FFFF},
      '{1'b0, IDX_IO_LIMIT_HI, 32'h0, 4'hF, 32'h0000_0000},
      '{1'b0, IDX_CAP_HEAD, 32'h0, 4'hF, 32'h0000_0040},
      '{1'b0, IDX_ROM_BASE, 32'h0, 4'hF, 32'h0000_0000},
      '{1'b0, IDX_IRQ_SCRATCH, 32'h0, 4'hF, 32'h0000_0000},
      '{1'b1, IDX_IRQ_SCRATCH, 32'hFFFF_FFA5, 4'hF, 32'h0000_00A5},
      '{1'b1, IDX_ROM_BASE, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000},
      '{1'b1, IDX_PF_LIMIT_LO, 32'hFFFF_FFFF, 4'hF, 32'h0000_FFF1},
      '{1'b1, IDX_PF_BASE_HI, 32'h1234_5678, 4'hF, 32'h1234_5678},
      '{1'b1, IDX_PF_BASE_HI, 32'h0000_00AB, 4'h1, 32'h1234_56AB},
      '{1'b1, IDX_PF_LIMIT_HI, 32'h9ABC_DEF0, 4'hF, 32'h9ABC_DEF0},
      '{1'b1, IDX_IO_BASE_HI, 32'hFFFF_1234, 4'hF, 32'h0000_1234},
      '{1'b1, IDX_IO_LIMIT_HI, 32'h0000_5678, 4'hF, 32'h0000_5678},
      '{1'b0, 10'h100, 32'h0, 4'hF, 32'h0000_0000},
      '{1'b1, IDX_CAP_HEAD, 32'h0000_0050, 4'hF, 32'h0000_0050}
   };

   logic clk_i;
   logic rst_i;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [ADDR_W-1:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [DATA_W-1:0] wb_dat_i;
   logic [DATA_W-1:0] wb_dat_o;
   logic wb_ack_o;
   logic [63:0] pf_probe_addr_i;
   logic [31:0] io_probe_addr_i;
   logic pf_hit_o;
   logic io_hit_o;
   int err_count = 0;
   int comparisons = 0;
   logic [63:0] pf_pt [0:3] = '{64'h1_0010_0000, 64'h1_000F_FFFF, 64'h1_002F_FFFF,
                               64'h1_0030_0000};
   logic [31:0] io_pt [0:3] = '{32'h0005_2000, 32'h0005_1FFF, 32'h0005_3FFF,
                               32'h0005_4000};
   logic hit_exp [0:3] = '{1'b1, 1'b0, 1'b1, 1'b0};

   bridge_window_upper_config_regs DUT (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .pf_probe_addr_i(pf_probe_addr_i), .io_probe_addr_i(io_probe_addr_i),
      .pf_hit_o(pf_hit_o), .io_hit_o(io_hit_o)
   );

   // ****************************************************************
   // Clock, bus tasks and closing
   // ****************************************************************
   // Free running 200 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // Print counts and verdict, then stop
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   // One classic Wishbone cycle; waits for ack, the watchdog ends a hang
   task automatic bus(input logic we, input logic [9:0] idx, input logic [31:0] dat,
                      input logic [3:0] sel, output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      // Ack comes one cycle after the taking edge
      `CHK(n, 2)
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : bus

   task automatic wr(input logic [9:0] idx, input logic [31:0] dat);
      logic [31:0] d;
      bus(1'b1, idx, dat, 4'hF, d);
   endtask : wr

   // Read a register and compare with the expected word
   task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, idx, 32'h0, 4'hF, d);
      `CHK(d, exp)
   endtask : rd

   // Reset for two cycles
   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   // Watchdog cuts a hang short
   initial
   begin
      #100000;
      err_count++;
      end_of_test();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      logic [31:0] d;
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = '0;
      wb_sel_i = 4'h0;
      wb_dat_i = '0;
      pf_probe_addr_i = '0;
      io_probe_addr_i = '0;
      do_reset();
      // Table of reset values, writes and read-backs
      for (int i = 0; i < NROWS; i++)
      begin
         if (ROWS[i].we)
            bus(1'b1, ROWS[i].idx, ROWS[i].dat, ROWS[i].sel, d);
         bus(1'b0, ROWS[i].idx, 32'h0, 4'hF, d);
         `CHK(d, ROWS[i].exp)
      end
      // Prefetch flag cleared: upper registers zero and read-only
      wr(IDX_PF_BASE_LO, 32'h0000_0010);
      rd(IDX_PF_LIMIT_LO, 32'h0000_FFF0);
      rd(IDX_PF_BASE_HI, 32'h0);
      rd(IDX_PF_LIMIT_HI, 32'h0);
      wr(IDX_PF_BASE_HI, 32'hDEAD_BEEF);
      rd(IDX_PF_BASE_HI, 32'h0);
      wr(IDX_PF_BASE_LO, 32'h0000_0011);
      rd(IDX_PF_LIMIT_LO, 32'h0000_FFF1);
      // I/O flag cleared: I/O upper registers zero and read-only
      wr(IDX_IO_LOW, 32'h0);
      rd(IDX_IO_BASE_HI, 32'h0);
      wr(IDX_IO_BASE_HI, 32'h0000_1111);
      rd(IDX_IO_BASE_HI, 32'h0);
      // Windows at their edges
      wr(IDX_PF_LIMIT_LO, 32'h0000_0020);
      wr(IDX_PF_BASE_HI, 32'h1);
      wr(IDX_PF_LIMIT_HI, 32'h1);
      wr(IDX_IO_LOW, 32'h0000_3021);
      wr(IDX_IO_BASE_HI, 32'h5);
      wr(IDX_IO_LIMIT_HI, 32'h5);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_i);
         pf_probe_addr_i <= pf_pt[i];
         io_probe_addr_i <= io_pt[i];
         repeat (2) @(posedge clk_i);
         #1;
         `CHK(pf_hit_o, hit_exp[i])
         `CHK(io_hit_o, hit_exp[i])
      end
      // Lock freezes capability head and prefetch flag
      wr(IDX_LOCK, 32'h1);
      wr(IDX_CAP_HEAD, 32'h0000_0060);
      rd(IDX_CAP_HEAD, 32'h0000_0050);
      wr(IDX_PF_BASE_LO, 32'h0000_0010);
      rd(IDX_PF_BASE_LO, 32'h0000_0011);
      rd(IDX_PF_BASE_HI, 32'h1);
      // Reset in mid-run restores defaults and clears the lock
      do_reset();
      rd(IDX_IRQ_SCRATCH, 32'h0);
      rd(IDX_CAP_HEAD, 32'h0000_0040);
      rd(IDX_PF_BASE_LO, 32'h0000_FFF1);
      wr(IDX_CAP_HEAD, 32'h0000_0070);
      rd(IDX_CAP_HEAD, 32'h0000_0070);
      @(posedge clk_i);
      `CHK(wb_ack_o, 1'b0)
      end_of_test();
   end
endmodule : tb
